// File: design/tmz_pkg.sv
// package: register map, field positions and timing for the timer block
package tmz_pkg;
	// register word indices (printed offsets are not word multiples)
	localparam logic [7:0] IDX_COUNT  = 8'h01;
	localparam logic [7:0] IDX_INTCTL = 8'h0b;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_PORTA  = 8'h85;
	localparam logic [7:0] IDX_CTRL   = 8'h90;
	localparam logic [7:0] IDX_STATUS = 8'h91;

	// option fields
	localparam int OPT_SRC   = 5;
	localparam int OPT_EDGE  = 4;
	localparam int OPT_PSA   = 3;
	localparam int OPT_PS_HI = 2;
	// interrupt control fields
	localparam int ICR_FLAG  = 2;
	localparam int ICR_EN    = 5;
	// own control register fields
	localparam int CTL_SLEEP = 0;
	localparam int CTL_WCLR  = 1;

	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] PORTA_RST  = 8'h1f;
	localparam logic [7:0] PORTA_MASK = 8'h1f;
	localparam logic [7:0] ZERO8      = 8'h00;
	localparam logic [7:0] ONE8       = 8'h01;
	localparam logic [7:0] MAX8       = 8'hff;

	// one oscillator period per ref_clk; instruction cycle is four phases
	localparam int TOSC_NS       = 4;
	localparam int CLK_NS        = 4;
	localparam int PHASES        = 4;
	localparam int TOSC_CYC      = (TOSC_NS + CLK_NS - 1) / CLK_NS;
	localparam int INHIBIT_INSTR = 2;
	localparam int ROLL_TOSC     = 3;
	localparam logic [1:0] PH_TWO  = 2'h1;
	localparam logic [1:0] PH_FOUR = 2'h3;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic [3:0] INH_CYC =
		4'(INHIBIT_INSTR * PHASES * TOSC_CYC);
	localparam logic [1:0] ROLL_CYC = 2'(ROLL_TOSC * TOSC_CYC);

	typedef struct packed {
		logic        read;
		logic        write;
		logic [9:0]  address;
		logic [31:0] writedata;
	} tmz_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} tmz_rsp_type;

	typedef struct packed {
		logic [7:0]  count;
		logic [7:0]  intctl;
		logic [7:0]  option;
		logic [7:0]  porta_dir;
		logic        sleep;
		logic [7:0]  presc;
		logic [3:0]  inhibit;
		logic [1:0]  phase;
		logic        pin_s1;
		logic        pin_s2;
		logic        pin_prev;
		logic [7:0]  ripple;
		logic        samp_q2;
		logic        samp_q4;
		logic        samp_prev;
		logic        roll_pend;
		logic [1:0]  roll_cnt;
		logic        wdt_tick;
		logic        ack;
		logic [31:0] rdata;
	} tmz_state_type;
endpackage

// File: design/tmz_timer.sv
// timer/counter with shared 8-bit prescaler behind an avalon-mm slave
//
// Behaviour
// - source bit zero: count each instruction cycle
// - count write blocks increments two instruction cycles
// - source bit one: count external pin edges
// - edge bit zero rising, one falling
// - assign bit zero: prescaler to timer, else watchdog
// - low option bits set owner and ratio
// - prescaler is 8-bit, not software visible
// - count write clears timer-owned prescaler
// - watchdog clear clears watchdog-owned prescaler
// - wrap ff to 00 sets overflow flag
// - enable bit zero masks overflow request
// - timer frozen during sleep
// - flag sets at once, rollover three periods later
// - clock sampled on phases two and four
// - external prescale ripple before synchronisation
// - increment 3 to 7 periods after input change; the code takes 9 to 12
// - count register 8-bit read/write at 01h
//
// The Avalon-MM register port is this design's own decision.
module tmz_timer
	import tmz_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// register bus
	input  wire tmz_req_type bus_req,
	output tmz_rsp_type      bus_rsp,
	// pins and system strobes
	input  wire logic        external_count_pin,
	input  wire logic        watchdog_clear_instruction,
	// outputs
	output logic             overflow_irq,
	output logic             watchdog_tick
);

	tmz_state_type r;
	tmz_state_type next_r;

	// tap of an 8-bit divide chain for ratio 2^(n+1)
	function automatic logic tap(input logic [7:0] c, input logic [2:0] n);
		tap = c[n];
	endfunction

	logic [7:0] addr8;
	logic       hit;
	logic       src_ext;
	logic       to_timer;
	logic       pin_edge;
	logic       raw_clk;
	logic       tick;
	logic       cnt_wr;
	logic       instr_end;
	logic       direct;
	logic       src_lvl;
	logic       ctl_wr;
	logic       int_wr;
	logic       presc_step;
	logic       presc_wrap;
	logic       wclr_any;
	logic       step;
	logic       wrap;

	// -----------------------------------------------------------------
	// bus decode and clocking
	// -----------------------------------------------------------------
	always_comb begin
		addr8     = bus_req.address[9:2];
		hit       = (bus_req.read | bus_req.write) & ~r.ack;
		src_ext   = r.option[OPT_SRC];
		to_timer  = ~r.option[OPT_PSA];
		instr_end = (r.phase == PH_LAST);
		cnt_wr    = hit & bus_req.write & (addr8 == IDX_COUNT);
		// selected edge of synchronised pin
		pin_edge  = r.option[OPT_EDGE] ? (r.pin_prev & ~r.pin_s2)
		                               : (~r.pin_prev & r.pin_s2);
		ctl_wr    = hit & bus_req.write & (addr8 == IDX_CTRL);
		int_wr    = hit & bus_req.write & (addr8 == IDX_INTCTL);
		// the sampler passes one rising edge per two instructions at best,
		// so the unprescaled internal source bypasses it
		direct    = ~src_ext & ~to_timer;
		// pin level turned so that the selected edge always rises
		src_lvl   = r.pin_s2 ^ r.option[OPT_EDGE];
		// external path divides before sampling; symmetric square out
		raw_clk   = to_timer ? tap(r.ripple, r.option[OPT_PS_HI:0])
		                     : src_lvl;
		tick      = r.samp_q4 & ~r.samp_prev;
		// a watchdog-owned prescaler runs off the instruction rate
		presc_step = ~r.sleep
		             & ((to_timer & src_ext) ? pin_edge : instr_end);
		presc_wrap = presc_step & (r.ripple == MAX8);
		wclr_any   = watchdog_clear_instruction
		             | (ctl_wr & bus_req.writedata[CTL_WCLR]);
		step       = ~r.sleep & instr_end & (r.inhibit == 4'h0)
		             & (direct | tick);
		wrap       = step & (r.count == MAX8);
	end

	always_comb begin
		next_r          = r;
		next_r.ack      = hit;
		next_r.rdata    = '0;
		next_r.wdt_tick = 1'b0;
		next_r.phase    = r.phase + 2'h1;
		next_r.pin_s1   = external_count_pin;
		next_r.pin_s2   = r.pin_s1;
		next_r.pin_prev = r.pin_s2;
		if (r.inhibit != 4'h0) begin
			next_r.inhibit = r.inhibit - 4'h1;
		end

		// prescaler chain steps on the selected pin edge when the timer owns it with the external source, else once per instruction
		if (presc_step) begin
			next_r.ripple = r.ripple + ONE8;
		end

		// sample the clock on phase two and phase four
		if (r.phase == PH_TWO) begin
			next_r.samp_q2 = raw_clk;
		end
		if (r.phase == PH_FOUR) begin
			next_r.samp_q4   = r.samp_q2;
			next_r.samp_prev = r.samp_q4;
		end

		// prescaler owned by watchdog emits a watchdog tick on each wrap
		next_r.presc = r.ripple;
		if (presc_wrap & ~to_timer) begin
			next_r.wdt_tick = 1'b1;
		end

		// synchronised tick: ff sets flag now, value wraps later
		if (step) begin
			if (r.count == MAX8) begin
				next_r.roll_pend = 1'b1;
				next_r.roll_cnt  = ROLL_CYC - 2'h1;
			end else begin
				next_r.count = r.count + ONE8;
			end
		end
		if (r.roll_pend) begin
			if (r.roll_cnt == 2'h0) begin
				next_r.roll_pend = 1'b0;
				next_r.count     = ZERO8;
			end else begin
				next_r.roll_cnt = r.roll_cnt - 2'h1;
			end
		end

		// watchdog clear resets a watchdog-owned prescaler
		if (wclr_any & ~to_timer) begin
			next_r.ripple = ZERO8;
		end

		// register writes
		if (hit & bus_req.write) begin
			unique case (addr8)
				IDX_COUNT: begin
					next_r.count     = bus_req.writedata[7:0];
					next_r.roll_pend = 1'b0;
					next_r.inhibit   = INH_CYC;
					if (to_timer) begin
						next_r.ripple = ZERO8;
					end
				end
				IDX_INTCTL: begin
					next_r.intctl = bus_req.writedata[7:0];
				end
				IDX_OPTION: next_r.option = bus_req.writedata[7:0];
				IDX_PORTA:  next_r.porta_dir = bus_req.writedata[7:0] & PORTA_MASK;
				IDX_CTRL: begin
					next_r.sleep = bus_req.writedata[CTL_SLEEP];
				end
				default: begin
				end
			endcase
		end

		// set after the write: a wrap beats a clear in the same cycle
		if (wrap) begin
			next_r.intctl[ICR_FLAG] = 1'b1;
		end

		// register reads
		if (hit & bus_req.read) begin
			unique case (addr8)
				IDX_COUNT:  next_r.rdata[7:0] = r.count;
				IDX_INTCTL: next_r.rdata[7:0] = r.intctl;
				IDX_OPTION: next_r.rdata[7:0] = r.option;
				IDX_PORTA:  next_r.rdata[7:0] = r.porta_dir;
				IDX_CTRL:   next_r.rdata[CTL_SLEEP] = r.sleep;
				IDX_STATUS: next_r.rdata[0] = r.roll_pend;
				default:    next_r.rdata = '0;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r           <= '0;
			r.option    <= OPTION_RST;
			r.porta_dir <= PORTA_RST;
		end else begin
			r <= next_r;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	always_comb begin
		bus_rsp.waitrequest = ~r.ack;
		bus_rsp.readdata    = r.rdata;
		overflow_irq  = r.intctl[ICR_FLAG] & r.intctl[ICR_EN];
		watchdog_tick = r.wdt_tick;
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	count_inhibit_a: assert property (@(posedge ref_clk) disable iff (srst)
		cnt_wr |=> (!step)[*7])
		else $error("count moved during write inhibit");

	presc_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		cnt_wr && to_timer |=> r.ripple == ZERO8)
		else $error("prescaler not cleared by count write");

	wdt_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		watchdog_clear_instruction && !to_timer && !hit |=> r.ripple == ZERO8)
		else $error("prescaler not cleared by watchdog clear");

	flag_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		!r.roll_pend ##1 r.roll_pend |-> r.intctl[ICR_FLAG])
		else $error("overflow flag not set on wrap");

	roll_late_a: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(r.roll_pend) && !hit |-> r.count == MAX8 ##3 r.count == ZERO8)
		else $error("rollover not three periods after flag");

	irq_mask_a: assert property (@(posedge ref_clk) disable iff (srst)
		!r.intctl[ICR_EN] |-> !overflow_irq)
		else $error("masked overflow request raised");

	sleep_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.sleep && !hit && !r.roll_pend |=> $stable(r.count))
		else $error("count moved in sleep");

	bus_ack_a: assert property (@(posedge ref_clk) disable iff (srst)
		(bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
		else $error("slave did not answer in one cycle");

	// -----------------------------------------------------------------
	// bus and register checks
	// -----------------------------------------------------------------
	ack_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
		!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
		else $error("answer stood longer than one cycle");

	wait_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		!bus_req.read && !bus_req.write |=> bus_rsp.waitrequest)
		else $error("answer without a request");

	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		!r.ack |-> bus_rsp.readdata == '0)
		else $error("read data outside the answer cycle");

	count_write_a: assert property (@(posedge ref_clk) disable iff (srst)
		cnt_wr |=> r.count == $past(bus_req.writedata[7:0]))
		else $error("count write did not land");

	opt_write_a: assert property (@(posedge ref_clk) disable iff (srst)
		hit && bus_req.write && addr8 == IDX_OPTION
		|=> r.option == $past(bus_req.writedata[7:0]))
		else $error("option write did not land");

	// -----------------------------------------------------------------
	// counting checks
	// -----------------------------------------------------------------
	inhibit_load_a: assert property (@(posedge ref_clk) disable iff (srst)
		cnt_wr |=> r.inhibit == INH_CYC)
		else $error("inhibit not loaded by count write");

	inhibit_run_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.inhibit != 4'h0 |-> !step)
		else $error("count stepped during inhibit");

	direct_step_a: assert property (@(posedge ref_clk) disable iff (srst)
		direct && step && r.count != MAX8 && !hit
		|=> r.count == $past(r.count) + ONE8)
		else $error("timer mode did not step by one");

	timer_pace_a: assert property (@(posedge ref_clk) disable iff (srst)
		!src_ext && !hit && !r.roll_pend && !instr_end |=> $stable(r.count))
		else $error("timer mode stepped off the instruction end");

	ext_tick_a: assert property (@(posedge ref_clk) disable iff (srst)
		src_ext && !hit && !r.roll_pend && !(tick && instr_end)
		|=> $stable(r.count))
		else $error("counter mode stepped without a sampled edge");

	edge_pick_a: assert property (@(posedge ref_clk) disable iff (srst)
		src_ext && to_timer && !r.option[OPT_EDGE] && r.pin_prev && !r.pin_s2
		|-> !presc_step)
		else $error("falling pin edge counted with rising selected");

	sample_q2_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.phase != PH_TWO |=> $stable(r.samp_q2))
		else $error("first sampler moved off phase two");

	sample_q4_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.phase != PH_FOUR |=> $stable(r.samp_q4))
		else $error("second sampler moved off phase four");

	sleep_presc_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.sleep && !hit && !wclr_any |=> $stable(r.ripple))
		else $error("prescaler moved in sleep");

	// -----------------------------------------------------------------
	// prescaler owner and overflow checks
	// -----------------------------------------------------------------
	wdt_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
		to_timer |=> !watchdog_tick)
		else $error("watchdog tick while timer owns prescaler");

	wdt_wrap_a: assert property (@(posedge ref_clk) disable iff (srst)
		!to_timer && presc_wrap |=> watchdog_tick)
		else $error("watchdog tick missing on prescaler wrap");

	wclr_ctl_a: assert property (@(posedge ref_clk) disable iff (srst)
		ctl_wr && bus_req.writedata[CTL_WCLR] && !to_timer |=> r.ripple == ZERO8)
		else $error("prescaler not cleared by control write");

	flag_win_a: assert property (@(posedge ref_clk) disable iff (srst)
		wrap |=> r.intctl[ICR_FLAG])
		else $error("wrap lost against a flag clear");

	flag_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.intctl[ICR_FLAG] && !int_wr |=> r.intctl[ICR_FLAG])
		else $error("hardware cleared the overflow flag");

	irq_raise_a: assert property (@(posedge ref_clk) disable iff (srst)
		r.intctl[ICR_FLAG] && r.intctl[ICR_EN] |-> overflow_irq)
		else $error("enabled overflow request missing");

	roll_end_a: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(r.roll_pend) && !hit ##1 !hit ##1 !hit |=> !r.roll_pend)
		else $error("rollover pending too long");

endmodule

// File: verification/tmz_edge_src.sv
// far-side model: an external count clock source on the count pin
module tmz_edge_src
	import tmz_pkg::*;
#(
	parameter int HALF = 6
)
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       srst,
	// command from the bench
	input  wire logic       go,
	input  wire logic [7:0] req_edges,
	// pin side
	output logic            pin,
	output logic            busy
);
	logic [7:0] left;
	logic [3:0] t;

	assign busy = (left != 8'h00);

	// level stands still between bursts, so no stray edge reaches the timer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin  <= 1'b0;
			left <= 8'h00;
			t    <= 4'h0;
		end else if (go) begin
			left <= req_edges;
			t    <= 4'h0;
		end else if (busy) begin
			t <= t + 4'h1;
			// each level held well over two oscillator periods
			if (t == 4'(HALF - 1)) begin
				t    <= 4'h0;
				pin  <= !pin;
				left <= left - 8'h01;
			end
		end
	end
endmodule

// File: verification/tmz_timer_tb.sv
// testbench: register-level checks of the timer block
module tmz_timer_tb
	import tmz_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [9:0] A_CNT = {IDX_COUNT, 2'b00};
	localparam logic [9:0] A_INT = {IDX_INTCTL, 2'b00};
	localparam logic [9:0] A_OPT = {IDX_OPTION, 2'b00};
	localparam logic [9:0] A_DIR = {IDX_PORTA, 2'b00};
	localparam logic [9:0] A_CTL = {IDX_CTRL, 2'b00};

	logic        ref_clk, srst, wclr, go, pin, busy, irq, tick;
	logic [7:0]  nedge, v, a, ticks;
	int          miscompares, cmp_count;
	tmz_req_type req;
	tmz_rsp_type rsp;

	tmz_timer uut (.ref_clk(ref_clk), .srst(srst), .bus_req(req),
		.bus_rsp(rsp), .external_count_pin(pin),
		.watchdog_clear_instruction(wclr), .overflow_irq(irq),
		.watchdog_tick(tick));
	tmz_edge_src src (.ref_clk(ref_clk), .srst(srst), .go(go),
		.req_edges(nedge), .pin(pin), .busy(busy));

	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [9:0] ad, input logic [7:0] d);
		req.address <= ad;
		req.writedata <= {24'h0, d};
		req.write <= 1'b1;
		do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
		req.write <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [9:0] ad);
		req.address <= ad;
		req.read <= 1'b1;
		do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
		v = rsp.readdata[7:0];
		req.read <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] lo, hi);
		cmp_count++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h..%h",
				$time, g, lo, hi);
		end
	endtask

	task automatic wclr_pulse();
		wclr <= 1'b1;
		@(posedge ref_clk);
		wclr <= 1'b0;
		@(posedge ref_clk);
	endtask

	// owner changes always clear count and watchdog before the option write
	task automatic opt(input logic [7:0] o);
		wr(A_CNT, 8'h00);
		wclr_pulse();
		wr(A_OPT, o);
		wr(A_CNT, 8'h00);
	endtask

	task automatic edges(input logic [7:0] n);
		nedge <= n;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		do @(posedge ref_clk); while (busy);
		repeat (20) @(posedge ref_clk);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, monitors, watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = !ref_clk;
	end

	always @(posedge ref_clk) if (tick === 1'b1) ticks <= ticks + 8'h01;

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		results();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		wclr = 1'b0;
		go = 1'b0;
		nedge = 8'h00;
		ticks = 8'h00;
		req = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd(A_OPT); chk(v, OPTION_RST, OPTION_RST);
		rd(A_DIR); chk(v, PORTA_RST, PORTA_RST);
		rd(A_INT); chk(v, 8'h00, 8'h00);
		wr(A_DIR, 8'hff); rd(A_DIR); chk(v, 8'h1f, 8'h1f);
		rd(10'h3fc); chk(v, 8'h00, 8'h00);
		// timer without prescaler, then ratios 1:2 .. 1:16
		for (int k = 0; k < 5; k++) begin
			opt(k == 0 ? 8'h08 : 8'(k - 1));
			wr(A_CNT, 8'h00);
			repeat (400) @(posedge ref_clk);
			rd(A_CNT);
			chk(v, 8'(100 >> k) - 8'h03, 8'(100 >> k) + 8'h01);
		end
		opt(8'h08);
		wr(A_CNT, 8'h80); rd(A_CNT); chk(v, 8'h80, 8'h80);
		wr(A_INT, 8'h00);
		wr(A_CNT, 8'hfd);
		repeat (40) @(posedge ref_clk);
		rd(A_INT); chk(v, 8'h04, 8'h04);
		chk({7'h0, irq}, 8'h00, 8'h00);
		wr(A_INT, 8'h00); rd(A_INT); chk(v, 8'h00, 8'h00);
		wr(A_INT, 8'h20);
		chk({7'h0, irq}, 8'h00, 8'h00);
		wr(A_CNT, 8'hfd);
		repeat (40) @(posedge ref_clk);
		chk({7'h0, irq}, 8'h01, 8'h01);
		rd(A_INT); chk(v, 8'h24, 8'h24);
		wr(A_CTL, 8'h01);
		rd(A_CNT);
		a = v;
		repeat (100) @(posedge ref_clk);
		rd(A_CNT); chk(v, a, a);
		wr(A_CTL, 8'h00);
		// counter mode, rising then falling edge selected
		opt(8'h28);
		edges(8'h01); rd(A_CNT); chk(v, 8'h01, 8'h01);
		edges(8'h01); rd(A_CNT); chk(v, 8'h01, 8'h01);
		opt(8'h38);
		edges(8'h01); rd(A_CNT); chk(v, 8'h00, 8'h00);
		edges(8'h01); rd(A_CNT); chk(v, 8'h01, 8'h01);
		edges(8'd20); rd(A_CNT); chk(v, 8'd11, 8'd11);
		// counter mode through the 1:2 prescaler, rising edges
		opt(8'h20);
		edges(8'd20); rd(A_CNT); chk(v, 8'd5, 8'd5);
		// prescaler with the watchdog: cleared often it never wraps
		opt(8'h08);
		ticks <= 8'h00;
		repeat (100) wclr_pulse();
		chk(ticks, 8'h00, 8'h00);
		// one prescaler wrap takes 256 instructions
		repeat (1100) @(posedge ref_clk);
		chk(ticks, 8'h01, 8'hff);
		opt(8'h00);
		ticks <= 8'h00;
		repeat (1100) @(posedge ref_clk);
		chk(ticks, 8'h00, 8'h00);
		results();
	end
endmodule
